// >>> common/rmac_pkg.sv
// shared constants and carriers of the modem / frequency-correction config bank
// assumes: a single 40 MHz clock domain, byte-wide register port
`default_nettype none
package rmac_pkg;
	// ----------------------------------------------------------------
	// register addresses in the radio register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam logic [9:0] ADDR_MODEM_SCHEME = 10'h115; // modem_scheme_config
	localparam logic [9:0] ADDR_TRACK_CFG = 10'h116; // freq_tracking_config
	localparam logic [9:0] ADDR_TRACK_GAINS = 10'h117; // freq_tracking_gains
	localparam logic [9:0] ADDR_IQ_PHASE = 10'h118; // iq_phase_trim_reg

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_MODEM_SCHEME = 8'h00;
	localparam logic [7:0] RST_TRACK_CFG = 8'h08; // scheme field at 2
	localparam logic [7:0] RST_TRACK_GAINS = 8'h37; // advised gains 3 and 7
	localparam logic [7:0] RST_IQ_PHASE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int IF_BANDWIDTH_SEL_MSB = 7;
	localparam int IF_BANDWIDTH_SEL_LSB = 6;
	localparam int TXMOD_MSB = 5;
	localparam int TXMOD_LSB = 3;
	localparam int RXDEM_MSB = 2;
	localparam int RXDEM_LSB = 0;
	localparam int TRK_RSVD_MSB = 7;
	localparam int TRK_RSVD_LSB = 5;
	localparam int TRK_POL_BIT = 4;
	localparam int TRK_SCHEME_MSB = 3;
	localparam int TRK_SCHEME_LSB = 2;
	localparam int TRK_MODE_MSB = 1;
	localparam int TRK_MODE_LSB = 0;
	localparam int KP_MSB = 7;
	localparam int KP_LSB = 4;
	localparam int KI_MSB = 3;
	localparam int KI_LSB = 0;
	localparam int PHASE_RSVD_BIT = 7;
	localparam int PHASE_MSB = 6;
	localparam int PHASE_LSB = 0;

	// ----------------------------------------------------------------
	// codes and figures
	// ----------------------------------------------------------------
	localparam logic [8:0] KHZ_100 = 9'h064;
	localparam logic [8:0] KHZ_150 = 9'h096;
	localparam logic [8:0] KHZ_200 = 9'h0c8;
	localparam logic [8:0] KHZ_300 = 9'h12c;
	localparam logic [1:0] IF_BANDWIDTH_SEL_300K = 2'h3;
	localparam logic [2:0] TXMOD_FSK = 3'h0;
	localparam logic [2:0] TXMOD_GFSK = 3'h1;
	localparam logic [2:0] TXMOD_CARRIER = 3'h3;
	localparam logic [2:0] RXDEM_FSK = 3'h0;
	localparam logic [1:0] TRK_SCHEME_REQ = 2'h2;

	// frequency-correction modes
	typedef enum logic [1:0] {
		FCM_FREE = 2'h0,
		FCM_OFF = 2'h1,
		FCM_HOLD = 2'h2,
		FCM_LOCK = 2'h3
	} rmac_fc_mode_t;

	// decoded transmit modulation, one flag per legal scheme
	typedef struct packed {
		logic fsk;
		logic gfsk;
		logic carrier;
		logic reserved;
	} rmac_tx_mod_t;

	// frequency-correction loop control toward the analog loop
	typedef struct packed {
		logic track;
		logic freeze;
		logic off;
		logic locked;
	} rmac_fc_ctrl_t;
endpackage
`default_nettype wire

// >>> hdl/rmac_afc_ctrl.sv
// frequency-correction loop sequencer: free run, off, hold, and lock-on-detect
// assumes: detect inputs are one-cycle pulses from the packet front end
`timescale 1ns/1ps
`default_nettype none
module rmac_afc_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// mode select from configuration
	input wire logic [1:0] mode,
	// packet front-end events
	input wire logic preamble_det,
	input wire logic sync_det,
	input wire logic rx_restart,
	input wire logic [3:0] preamble_match,
	// loop control out
	output rmac_pkg::rmac_fc_ctrl_t ctrl
);
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_OFF = 5'h02,
		ST_HOLD = 5'h04,
		ST_SEEK = 5'h08,
		ST_LOCK = 5'h10
	} rmac_afc_st_t;

	rmac_afc_st_t state; // current sequencer state
	rmac_afc_st_t next_state; // state for the next edge
	logic lock_event; // qualified detect that closes the lock

	// ----------------------------------------------------------------
	// lock qualification
	// ----------------------------------------------------------------
	// sync word only counts when preamble detection is switched off
	assign lock_event = (preamble_match != 4'h0) ? preamble_det : sync_det;

	// next state follows the mode field each cycle
	always_comb begin
		next_state = state;
		unique case (rmac_pkg::rmac_fc_mode_t'(mode))
			rmac_pkg::FCM_FREE: next_state = ST_RUN;
			rmac_pkg::FCM_OFF: next_state = ST_OFF;
			rmac_pkg::FCM_HOLD: next_state = ST_HOLD;
			rmac_pkg::FCM_LOCK: begin
				if (rx_restart || (state != ST_SEEK && state != ST_LOCK)) begin
					next_state = ST_SEEK;
				end else if (state == ST_SEEK && lock_event) begin
					next_state = ST_LOCK;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// registered loop controls, decoded from the next state so they match state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl <= '0;
		end else begin
			ctrl.track <= (next_state == ST_RUN) || (next_state == ST_SEEK);
			ctrl.freeze <= (next_state == ST_HOLD) || (next_state == ST_LOCK);
			ctrl.off <= (next_state == ST_OFF);
			ctrl.locked <= (next_state == ST_LOCK);
		end
	end
endmodule
`default_nettype wire

// >>> hdl/rmac_cfg_regs.sv
// modem scheme and frequency-correction configuration register bank
// assumes: byte-wide register port of the radio map, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - bandwidth field picks 100/150/200/300 kHz
// - 300 kHz bandwidth moves IF to 300
// - tx field: FSK, GFSK, carrier; others reserved
// - rx field: only code zero is legal
// - loop modes: free, disabled, paused hold
// - lock mode: lock on preamble or sync
// - proportional gain is two to field
// - integral gain is two to field
// - seven-bit phase trim, bit seven zero
module rmac_cfg_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// packet front-end events for the lock mode
	input wire logic preamble_det,
	input wire logic sync_det,
	input wire logic rx_restart,
	input wire logic [3:0] preamble_match,
	// receive path configuration
	output logic [1:0] if_bandwidth_sel,
	output logic [8:0] if_bandwidth_khz,
	output logic [8:0] if_freq_khz,
	output logic if_freq_high,
	output logic rx_demod_valid,
	output logic [6:0] iq_phase_trim,
	// transmit path configuration
	output rmac_pkg::rmac_tx_mod_t tx_mod,
	// frequency-correction loop
	output rmac_pkg::rmac_fc_ctrl_t fc_ctrl,
	output logic [15:0] prop_gain_lin,
	output logic [15:0] int_gain_lin,
	// configuration health
	output logic cfg_reserved_used
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] modem_scheme_config; // bandwidth, tx and rx scheme
	logic [7:0] freq_tracking_config; // loop polarity, scheme and mode
	logic [7:0] freq_tracking_gains; // loop gain exponents
	logic [7:0] iq_phase_trim_reg; // image-rejection phase trim

	// field views
	logic [2:0] tx_modulation_sel; // transmit modulation code
	logic [2:0] rx_demodulation_sel; // receive demodulation code
	logic [1:0] freq_correction_mode; // loop mode code
	logic [3:0] freq_loop_prop_gain; // proportional exponent
	logic [3:0] freq_loop_int_gain; // integral exponent
	logic freq_loop_polarity; // must stay zero
	logic [1:0] freq_loop_scheme; // must stay at two

	// next values of the decoded outputs
	logic [8:0] next_bw_khz;
	logic [8:0] next_if_khz;
	rmac_pkg::rmac_tx_mod_t next_tx_mod;
	logic next_reserved;
	logic [7:0] next_rdata;

	// write strobes per register
	logic wr_modem;
	logic wr_track;
	logic wr_gains;
	logic wr_phase;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign wr_modem = reg_wr && (reg_addr == rmac_pkg::ADDR_MODEM_SCHEME);
	assign wr_track = reg_wr && (reg_addr == rmac_pkg::ADDR_TRACK_CFG);
	assign wr_gains = reg_wr && (reg_addr == rmac_pkg::ADDR_TRACK_GAINS);
	assign wr_phase = reg_wr && (reg_addr == rmac_pkg::ADDR_IQ_PHASE);

	// field slicing
	assign tx_modulation_sel = modem_scheme_config[rmac_pkg::TXMOD_MSB:rmac_pkg::TXMOD_LSB];
	assign rx_demodulation_sel = modem_scheme_config[rmac_pkg::RXDEM_MSB:rmac_pkg::RXDEM_LSB];
	assign freq_correction_mode =
		freq_tracking_config[rmac_pkg::TRK_MODE_MSB:rmac_pkg::TRK_MODE_LSB];
	assign freq_loop_polarity = freq_tracking_config[rmac_pkg::TRK_POL_BIT];
	assign freq_loop_scheme =
		freq_tracking_config[rmac_pkg::TRK_SCHEME_MSB:rmac_pkg::TRK_SCHEME_LSB];
	assign freq_loop_prop_gain = freq_tracking_gains[rmac_pkg::KP_MSB:rmac_pkg::KP_LSB];
	assign freq_loop_int_gain = freq_tracking_gains[rmac_pkg::KI_MSB:rmac_pkg::KI_LSB];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// every bit is plain read/write, reserved ones included, so software
	// reads back exactly what it wrote; misuse is flagged, not masked
	always_ff @(posedge clk) begin
		if (!rstn) begin
			modem_scheme_config <= rmac_pkg::RST_MODEM_SCHEME;
		end else if (wr_modem) begin
			modem_scheme_config <= reg_wdata;
		end
	end

	// tracking configuration, fixed bits are left to software
	always_ff @(posedge clk) begin
		if (!rstn) begin
			freq_tracking_config <= rmac_pkg::RST_TRACK_CFG;
		end else if (wr_track) begin
			freq_tracking_config <= reg_wdata;
		end
	end

	// loop gains, reset to the advised pair
	always_ff @(posedge clk) begin
		if (!rstn) begin
			freq_tracking_gains <= rmac_pkg::RST_TRACK_GAINS;
		end else if (wr_gains) begin
			freq_tracking_gains <= reg_wdata;
		end
	end

	// phase trim
	always_ff @(posedge clk) begin
		if (!rstn) begin
			iq_phase_trim_reg <= rmac_pkg::RST_IQ_PHASE;
		end else if (wr_phase) begin
			iq_phase_trim_reg <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// unmapped addresses answer zero rather than stalling the port
	always_comb begin
		next_rdata = rmac_pkg::UNMAPPED_READ;
		if (reg_addr == rmac_pkg::ADDR_MODEM_SCHEME) begin
			next_rdata = modem_scheme_config;
		end else if (reg_addr == rmac_pkg::ADDR_TRACK_CFG) begin
			next_rdata = freq_tracking_config;
		end else if (reg_addr == rmac_pkg::ADDR_TRACK_GAINS) begin
			next_rdata = freq_tracking_gains;
		end else if (reg_addr == rmac_pkg::ADDR_IQ_PHASE) begin
			next_rdata = iq_phase_trim_reg;
		end
	end

	// read data one cycle after the strobe, held until the next read
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive filter decode
	// ----------------------------------------------------------------
	always_comb begin
		unique case (modem_scheme_config[rmac_pkg::IF_BANDWIDTH_SEL_MSB:rmac_pkg::IF_BANDWIDTH_SEL_LSB])
			2'h0: next_bw_khz = rmac_pkg::KHZ_100;
			2'h1: next_bw_khz = rmac_pkg::KHZ_150;
			2'h2: next_bw_khz = rmac_pkg::KHZ_200;
			2'h3: next_bw_khz = rmac_pkg::KHZ_300;
		endcase
	end

	// the widest filter no longer fits a 200 kHz IF, so the IF follows it
	assign next_if_khz = (modem_scheme_config[rmac_pkg::IF_BANDWIDTH_SEL_MSB:rmac_pkg::IF_BANDWIDTH_SEL_LSB]
		== rmac_pkg::IF_BANDWIDTH_SEL_300K) ? rmac_pkg::KHZ_300 : rmac_pkg::KHZ_200;

	// registered receive outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			if_bandwidth_sel <= 2'h0;
			if_bandwidth_khz <= rmac_pkg::KHZ_100;
			if_freq_khz <= rmac_pkg::KHZ_200;
			if_freq_high <= 1'b0;
		end else begin
			if_bandwidth_sel <= modem_scheme_config[rmac_pkg::IF_BANDWIDTH_SEL_MSB:rmac_pkg::IF_BANDWIDTH_SEL_LSB];
			if_bandwidth_khz <= next_bw_khz;
			if_freq_khz <= next_if_khz;
			if_freq_high <= (next_if_khz == rmac_pkg::KHZ_300);
		end
	end

	// ----------------------------------------------------------------
	// transmit and demodulation decode
	// ----------------------------------------------------------------
	// a reserved transmit code drives no scheme at all, the modulator idles
	always_comb begin
		next_tx_mod = '0;
		if (tx_modulation_sel == rmac_pkg::TXMOD_FSK) begin
			next_tx_mod.fsk = 1'b1;
		end else if (tx_modulation_sel == rmac_pkg::TXMOD_GFSK) begin
			next_tx_mod.gfsk = 1'b1;
		end else if (tx_modulation_sel == rmac_pkg::TXMOD_CARRIER) begin
			next_tx_mod.carrier = 1'b1;
		end else begin
			next_tx_mod.reserved = 1'b1;
		end
	end

	// any reserved code or fixed bit off its value raises the health flag
	always_comb begin
		next_reserved = next_tx_mod.reserved;
		if (rx_demodulation_sel != rmac_pkg::RXDEM_FSK) begin
			next_reserved = 1'b1;
		end
		if (iq_phase_trim_reg[rmac_pkg::PHASE_RSVD_BIT]) begin
			next_reserved = 1'b1;
		end
		if (freq_tracking_config[rmac_pkg::TRK_RSVD_MSB:rmac_pkg::TRK_RSVD_LSB] != 3'h0
			|| freq_loop_polarity || freq_loop_scheme != rmac_pkg::TRK_SCHEME_REQ) begin
			next_reserved = 1'b1;
		end
	end

	// registered transmit, demodulation, trim and health outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_mod <= '0;
			rx_demod_valid <= 1'b0;
			iq_phase_trim <= 7'h00;
			cfg_reserved_used <= 1'b0;
		end else begin
			tx_mod <= next_tx_mod;
			rx_demod_valid <= (rx_demodulation_sel == rmac_pkg::RXDEM_FSK);
			iq_phase_trim <= iq_phase_trim_reg[rmac_pkg::PHASE_MSB:rmac_pkg::PHASE_LSB];
			cfg_reserved_used <= next_reserved;
		end
	end

	// ----------------------------------------------------------------
	// frequency-correction loop
	// ----------------------------------------------------------------
	// mode sequencer, owns the lock handshake with the packet front end
	rmac_afc_ctrl u_afc (
		.clk(clk),
		.rstn(rstn),
		.mode(freq_correction_mode),
		.preamble_det(preamble_det),
		.sync_det(sync_det),
		.rx_restart(rx_restart),
		.preamble_match(preamble_match),
		.ctrl(fc_ctrl)
	);

	// proportional gain as a one-hot shift amount
	rmac_gain_shift u_prop_gain (
		.clk(clk),
		.rstn(rstn),
		.code(freq_loop_prop_gain),
		.gain(prop_gain_lin)
	);

	// integral gain as a one-hot shift amount
	rmac_gain_shift u_int_gain (
		.clk(clk),
		.rstn(rstn),
		.code(freq_loop_int_gain),
		.gain(int_gain_lin)
	);
endmodule
`default_nettype wire

// >>> hdl/rmac_gain_shift.sv
// power-of-two gain expander: turns a 4-bit exponent into a one-hot linear gain
// assumes: code is a static configuration value, output lags it by one clock
`timescale 1ns/1ps
`default_nettype none
module rmac_gain_shift (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// exponent in
	input wire logic [3:0] code,
	// linear gain out, 2 to the power code
	output logic [15:0] gain
);
	// ----------------------------------------------------------------
	// one flop per gain bit
	// ----------------------------------------------------------------
	// one-hot form lets the loop apply the gain as a pure shift, no multiplier
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rstn) begin
					gain[i] <= 1'b0;
				end else begin
					gain[i] <= (code == i[3:0]);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> testbench/rmac_cfg_regs_checker.sv
// concurrent checks on the ports of the modem / frequency-correction config bank
// assumes: one clock, synchronous active-low reset, bound onto rmac_cfg_regs
`timescale 1ns/1ps
`default_nettype none
module rmac_cfg_regs_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// packet front-end events
	input wire logic preamble_det,
	input wire logic sync_det,
	input wire logic rx_restart,
	input wire logic [3:0] preamble_match,
	// decoded configuration
	input wire logic [1:0] if_bandwidth_sel,
	input wire logic [8:0] if_bandwidth_khz,
	input wire logic [8:0] if_freq_khz,
	input wire logic if_freq_high,
	input wire logic rx_demod_valid,
	input wire logic [6:0] iq_phase_trim,
	input wire rmac_pkg::rmac_tx_mod_t tx_mod,
	input wire rmac_pkg::rmac_fc_ctrl_t fc_ctrl,
	input wire logic [15:0] prop_gain_lin,
	input wire logic [15:0] int_gain_lin
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [1:0] mode_q; // shadow of the loop mode field, kept from the write strobes
	logic wr_scheme; // write to the modem scheme register
	logic wr_track; // write to the tracking register
	logic wr_gains; // write to the gain register
	logic wr_phase; // write to the phase trim register
	assign wr_scheme = reg_wr && reg_addr == rmac_pkg::ADDR_MODEM_SCHEME;
	assign wr_track = reg_wr && reg_addr == rmac_pkg::ADDR_TRACK_CFG;
	assign wr_gains = reg_wr && reg_addr == rmac_pkg::ADDR_TRACK_GAINS;
	assign wr_phase = reg_wr && reg_addr == rmac_pkg::ADDR_IQ_PHASE;
	// shadow follows the register itself, so lock checks know the mode
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_q <= 2'h0;
		end else if (wr_track) begin
			mode_q <= reg_wdata[1:0];
		end
	end
	// one flag per transmit scheme, reserved codes raise only the last
	function automatic logic [3:0] tx_exp(input logic [2:0] c);
		return {c == 3'h0, c == 3'h1, c == 3'h3, !(c == 3'h0 || c == 3'h1 || c == 3'h3)};
	endfunction
	// searching means lock mode set, loop still tracking, no lock yet, and no tracking-register write or restart this cycle
	logic searching;
	assign searching = mode_q == 2'h3 && fc_ctrl == 4'h8 && !wr_track && !rx_restart;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_read_pulse: assert property (reg_rd |=> reg_rvalid)
		else $error("read answer missing one cycle after the strobe");
	chk_rdata_hold: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_bw_decode: assert property (if_bandwidth_khz == (if_bandwidth_sel == 2'h0 ? 9'h064 :
		if_bandwidth_sel == 2'h1 ? 9'h096 : if_bandwidth_sel == 2'h2 ? 9'h0c8 : 9'h12c))
		else $error("filter width does not follow its code");
	chk_if_shift: assert property (if_freq_high == (if_bandwidth_sel == 2'h3) &&
		if_freq_khz == (if_bandwidth_sel == 2'h3 ? 9'h12c : 9'h0c8))
		else $error("intermediate frequency does not follow the widest filter");
	chk_tx_decode: assert property (wr_scheme |=> ##1 tx_mod == tx_exp($past(reg_wdata[5:3], 2))
		&& if_bandwidth_sel == $past(reg_wdata[7:6], 2))
		else $error("transmit scheme or bandwidth code not decoded");
	chk_rx_decode: assert property (wr_scheme |=> ##1 rx_demod_valid ==
		($past(reg_wdata[2:0], 2) == 3'h0))
		else $error("receive scheme validity wrong");
	chk_mode_ctrl: assert property (wr_track && reg_wdata[1:0] != 2'h3 |=> ##1
		fc_ctrl == ($past(reg_wdata[1:0], 2) == 2'h0 ? 4'h8 :
		$past(reg_wdata[1:0], 2) == 2'h1 ? 4'h2 : 4'h4))
		else $error("loop controls do not follow the mode");
	chk_lock_preamble: assert property (searching && $past(searching) && preamble_det &&
		preamble_match != 4'h0 |=> fc_ctrl == 4'h5)
		else $error("no lock after preamble");
	chk_lock_sync: assert property (searching && $past(searching) && sync_det &&
		preamble_match == 4'h0 |=> fc_ctrl == 4'h5)
		else $error("no lock after sync word");
	chk_gain_expand: assert property (wr_gains |=> ##1
		prop_gain_lin == 16'h0001 << $past(reg_wdata[7:4], 2) &&
		int_gain_lin == 16'h0001 << $past(reg_wdata[3:0], 2))
		else $error("linear gain is not two to the field");
	chk_trim_copy: assert property (wr_phase |=> ##1 iq_phase_trim == $past(reg_wdata[6:0], 2))
		else $error("phase trim not taken from the register");
endmodule

bind rmac_cfg_regs rmac_cfg_regs_checker rmac_cfg_regs_checker_i (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .preamble_det(preamble_det),
	.sync_det(sync_det), .rx_restart(rx_restart), .preamble_match(preamble_match),
	.if_bandwidth_sel(if_bandwidth_sel), .if_bandwidth_khz(if_bandwidth_khz),
	.if_freq_khz(if_freq_khz), .if_freq_high(if_freq_high), .rx_demod_valid(rx_demod_valid),
	.iq_phase_trim(iq_phase_trim), .tx_mod(tx_mod), .fc_ctrl(fc_ctrl),
	.prop_gain_lin(prop_gain_lin), .int_gain_lin(int_gain_lin));
`default_nettype wire

// >>> testbench/test_radio_modem_afc_config_regs.sv
// self-checking bench of the modem / frequency-correction config bank
// assumes: package, design and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_radio_modem_afc_config_regs;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, rstn, reg_wr, reg_rd, reg_rvalid, preamble_det, sync_det, rx_restart;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] preamble_match;
	logic [1:0] if_bandwidth_sel;
	logic [8:0] if_bandwidth_khz, if_freq_khz;
	logic if_freq_high, rx_demod_valid, cfg_reserved_used;
	logic [6:0] iq_phase_trim;
	rmac_pkg::rmac_tx_mod_t tx_mod;
	rmac_pkg::rmac_fc_ctrl_t fc_ctrl;
	logic [15:0] prop_gain_lin, int_gain_lin;
	int n_errors = 0; // mismatches seen
	int n_tests = 0; // comparisons made

	rmac_cfg_regs rmac_cfg_regs_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .preamble_det(preamble_det), .sync_det(sync_det),
		.rx_restart(rx_restart), .preamble_match(preamble_match),
		.if_bandwidth_sel(if_bandwidth_sel), .if_bandwidth_khz(if_bandwidth_khz),
		.if_freq_khz(if_freq_khz), .if_freq_high(if_freq_high),
		.rx_demod_valid(rx_demod_valid), .iq_phase_trim(iq_phase_trim), .tx_mod(tx_mod),
		.fc_ctrl(fc_ctrl), .prop_gain_lin(prop_gain_lin), .int_gain_lin(int_gain_lin),
		.cfg_reserved_used(cfg_reserved_used));

	// ----------------------------------------------------------------
	// clock, verdict, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic results;
		$display("checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// the run needs about 200 cycles; fourteen times that is a hang
	initial begin
		#70000;
		n_errors = n_errors + 1;
		$display("unexpected at %0t ns: watchdog ran out", $time);
		results();
	end

	// ----------------------------------------------------------------
	// shared tasks; inputs move only on the falling edge
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	// write, then wait until the derived outputs have moved
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(16'(reg_rvalid), 16'h0001);
		chk(16'(reg_rdata), 16'(exp));
	endtask
	// one-cycle event pulse: preamble, sync word, restart
	task automatic pulse(input logic [2:0] p);
		@(negedge clk);
		{preamble_det, sync_det, rx_restart} = p;
		@(negedge clk);
		{preamble_det, sync_det, rx_restart} = 3'h0;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd(rmac_pkg::ADDR_MODEM_SCHEME, 8'h00);
		rd(rmac_pkg::ADDR_TRACK_CFG, 8'h08);
		rd(rmac_pkg::ADDR_TRACK_GAINS, 8'h37);
		rd(rmac_pkg::ADDR_IQ_PHASE, 8'h00);
		chk(prop_gain_lin, 16'h0008);
		chk(int_gain_lin, 16'h0080);
		chk(16'(fc_ctrl), 16'h0008);
		// unmapped place: write ignored, read gives zero
		wr(10'h119, 8'hff);
		rd(10'h119, 8'h00);
		$display("test reset values done");
	endtask
	task automatic t_bandwidth;
		logic [8:0] khz [4] = '{rmac_pkg::KHZ_100, rmac_pkg::KHZ_150, rmac_pkg::KHZ_200,
			rmac_pkg::KHZ_300};
		for (int i = 0; i < 4; i++) begin
			wr(rmac_pkg::ADDR_MODEM_SCHEME, {i[1:0], 6'h00});
			chk(16'(if_bandwidth_sel), 16'(i[1:0]));
			chk(16'(if_bandwidth_khz), 16'(khz[i]));
			chk(16'(if_freq_khz), (i == 3) ? 16'h012c : 16'h00c8);
			chk(16'(if_freq_high), 16'(i == 3));
			rd(rmac_pkg::ADDR_MODEM_SCHEME, {i[1:0], 6'h00});
		end
		$display("test bandwidth done");
	endtask
	task automatic t_schemes;
		logic [3:0] e;
		for (int c = 0; c < 8; c++) begin
			e = (c == 0) ? 4'h8 : (c == 1) ? 4'h4 : (c == 3) ? 4'h2 : 4'h1;
			wr(rmac_pkg::ADDR_MODEM_SCHEME, {2'h0, c[2:0], 3'h0});
			chk(16'(tx_mod), 16'(e));
			chk(16'(cfg_reserved_used), 16'(e[0]));
			wr(rmac_pkg::ADDR_MODEM_SCHEME, {5'h00, c[2:0]});
			chk(16'(rx_demod_valid), 16'(c == 0));
			chk(16'(cfg_reserved_used), 16'(c != 0));
		end
		// leave a legal demodulation code behind, later health checks expect a clean bank
		wr(rmac_pkg::ADDR_MODEM_SCHEME, 8'h00);
		chk(16'(cfg_reserved_used), 16'h0000);
		$display("test schemes done");
	endtask
	task automatic t_modes;
		logic [3:0] e;
		for (int m = 0; m < 3; m++) begin
			e = (m == 0) ? 4'h8 : (m == 1) ? 4'h2 : 4'h4;
			wr(rmac_pkg::ADDR_TRACK_CFG, {6'h02, m[1:0]});
			chk(16'(fc_ctrl), 16'(e));
		end
		wr(rmac_pkg::ADDR_TRACK_CFG, 8'h18);
		chk(16'(cfg_reserved_used), 16'h0001);
		wr(rmac_pkg::ADDR_TRACK_CFG, 8'h08);
		chk(16'(cfg_reserved_used), 16'h0000);
		$display("test loop modes done");
	endtask
	task automatic t_lock;
		preamble_match = 4'hc;
		wr(rmac_pkg::ADDR_TRACK_CFG, 8'h0b);
		@(negedge clk);
		chk(16'(fc_ctrl), 16'h0008);
		pulse(3'h2);
		chk(16'(fc_ctrl), 16'h0008);
		pulse(3'h4);
		chk(16'(fc_ctrl), 16'h0005);
		pulse(3'h1);
		chk(16'(fc_ctrl), 16'h0008);
		@(negedge clk);
		preamble_match = 4'h0;
		pulse(3'h4);
		chk(16'(fc_ctrl), 16'h0008);
		pulse(3'h2);
		chk(16'(fc_ctrl), 16'h0005);
		wr(rmac_pkg::ADDR_TRACK_CFG, 8'h08);
		chk(16'(fc_ctrl), 16'h0008);
		$display("test lock mode done");
	endtask
	task automatic t_gains;
		for (int k = 0; k < 16; k++) begin
			wr(rmac_pkg::ADDR_TRACK_GAINS, {k[3:0], ~k[3:0]});
			chk(prop_gain_lin, 16'h0001 << k);
			chk(int_gain_lin, 16'h0001 << (15 - k));
		end
		rd(rmac_pkg::ADDR_TRACK_GAINS, 8'hf0);
		wr(rmac_pkg::ADDR_TRACK_GAINS, 8'h37);
		$display("test gains done");
	endtask
	task automatic t_phase;
		wr(rmac_pkg::ADDR_IQ_PHASE, 8'hff);
		chk(16'(iq_phase_trim), 16'h007f);
		chk(16'(cfg_reserved_used), 16'h0001);
		rd(rmac_pkg::ADDR_IQ_PHASE, 8'hff);
		wr(rmac_pkg::ADDR_IQ_PHASE, 8'h2a);
		chk(16'(iq_phase_trim), 16'h002a);
		chk(16'(cfg_reserved_used), 16'h0000);
		$display("test phase trim done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		{reg_wr, reg_rd, preamble_det, sync_det, rx_restart} = 5'h00;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		preamble_match = 4'h0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_bandwidth();
		t_schemes();
		t_modes();
		t_lock();
		t_gains();
		t_phase();
		results();
	end
endmodule
`default_nettype wire
